// ===== design/afcd_pkg.sv
// Package: register map, field layout and serial framing constants
////////////////////////////////////////////////////////////////////
package afcd_pkg;

  // Register byte offsets
  localparam logic [7:0]  CFG_OFFSET    = 8'h1c;
  localparam logic [7:0]  PRESC_OFFSET  = 8'h20;
  localparam logic [7:0]  STATUS_OFFSET = 8'h24;

  // Reset values and writable bits
  localparam logic [15:0] CFG_RESET     = 16'h0000;
  localparam logic [15:0] PRESC_RESET   = 16'h0002;
  localparam logic [15:0] CFG_WMASK     = 16'h0fbf;
  localparam logic [15:0] PRESC_WMASK   = 16'h03ff;

  // Framing standards
  localparam logic [1:0]  STD_I2S       = 2'h0;
  localparam logic [1:0]  STD_LEFT      = 2'h1;
  localparam logic [1:0]  STD_RIGHT     = 2'h2;
  localparam logic [1:0]  STD_PCM       = 2'h3;

  // Sample length codes
  localparam logic [1:0]  LEN_16        = 2'h0;
  localparam logic [1:0]  LEN_24        = 2'h1;
  localparam logic [1:0]  LEN_32        = 2'h2;

  // Role codes
  localparam logic [1:0]  ROLE_SLAVE_TX  = 2'h0;
  localparam logic [1:0]  ROLE_SLAVE_RX  = 2'h1;
  localparam logic [1:0]  ROLE_MASTER_TX = 2'h2;
  localparam logic [1:0]  ROLE_MASTER_RX = 2'h3;

  // Bit counts on the line
  localparam logic [5:0]  BITS_16       = 6'h10;
  localparam logic [5:0]  BITS_24       = 6'h18;
  localparam logic [5:0]  BITS_32       = 6'h20;
  localparam logic [5:0]  PCM_LONG_BITS = 6'h0d;
  localparam logic [5:0]  IDX_RESET     = 6'h3f;

  // Format configuration register layout
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic       audio_function_select;
    logic       audio_port_enable;
    logic [1:0] audio_role_config;
    logic       pcm_sync_length;
    logic       rsvd_6;
    logic [1:0] framing_standard_sel;
    logic       idle_clock_polarity;
    logic [1:0] sample_length_sel;
    logic       channel_slot_width;
  } afcd_cfg_s;

  // Clock prescaler register layout
  typedef struct packed {
    logic [5:0] rsvd_hi;
    logic       master_clock_out_en;
    logic       odd_adjust;
    logic [7:0] linear_divider;
  } afcd_presc_s;

  // One stereo frame of samples, MSB aligned at the length
  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } afcd_pair_s;

  // APB request and answer
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } afcd_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } afcd_apb_rsp_s;

endpackage

// ===== design/afcd_clk_div.sv
// Linear prescaler producing the serial bit clock and its edge enables
`timescale 1ns/1ps
module afcd_clk_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [7:0] linear_divider,
  input  wire logic       odd_adjust,
  output logic            clk_level,
  output logic            rise,
  output logic            fall
);
  logic [8:0] coeff;
  logic [8:0] cnt;
  logic [8:0] gap;
  logic       seen;

  // period is twice divider plus odd
  // divider of one or more keeps both halves
  assign coeff = {linear_divider, 1'b0} + {8'h00, odd_adjust};
  assign rise  = run & (cnt == 9'(coeff - 9'h001));
  assign fall  = run & (cnt == 9'({1'b0, linear_divider} - 9'h001));

  // Cycle counter, restarts each period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 9'h000;
    end else if (!run || rise) begin
      cnt <= 9'h000;
    end else begin
      cnt <= 9'(cnt + 9'h001);
    end
  end

  // Divided clock level, high for the first half
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_level <= 1'b0;
    end else if (!run) begin
      clk_level <= 1'b0;
    end else if (rise) begin
      clk_level <= 1'b1;
    end else if (fall) begin
      clk_level <= 1'b0;
    end
  end

  // Gap between rises, watched only by the check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap  <= 9'h001;
      seen <= 1'b0;
    end else begin
      gap  <= (!run || rise) ? 9'h001 : 9'(gap + 9'h001);
      seen <= run & (seen | rise);
    end
  end

  // spacing of rises equals the coefficient
  chk_div_period: assert property (
    @(posedge clk) disable iff (rst) rise && seen |-> gap == coeff)
    else $error("bit clock period differs from prescaler coefficient");

endmodule

// ===== design/afcd_apb_regs.sv
// APB slave holding format, prescaler and status registers
`timescale 1ns/1ps
module afcd_apb_regs (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire afcd_pkg::afcd_apb_req_s req,
  output afcd_pkg::afcd_apb_rsp_s      rsp,
  output afcd_pkg::afcd_cfg_s          cfg,
  output afcd_pkg::afcd_presc_s        presc,
  input  wire logic [31:0]             status
);
  logic [31:0] prdata_q;
  logic        setup;
  logic        access;
  logic        hit_cfg;
  logic        hit_presc;
  logic        hit_stat;
  logic        mapped;

  // Phase and address decode
  assign setup     = req.psel & ~req.penable;
  assign access    = req.psel & req.penable;
  assign hit_cfg   = req.paddr == afcd_pkg::CFG_OFFSET;
  assign hit_presc = req.paddr == afcd_pkg::PRESC_OFFSET;
  assign hit_stat  = req.paddr == afcd_pkg::STATUS_OFFSET;
  assign mapped    = hit_cfg | hit_presc | hit_stat;

  // Format register, reserved bits kept zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= afcd_pkg::CFG_RESET;
    end else if (access && req.pwrite && hit_cfg) begin
      cfg <= req.pwdata[15:0] & afcd_pkg::CFG_WMASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc <= afcd_pkg::PRESC_RESET;
    end else if (access && req.pwrite && hit_presc) begin
      presc <= req.pwdata[15:0] & afcd_pkg::PRESC_WMASK;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !req.pwrite) begin
      if (hit_cfg) begin
        prdata_q <= {16'h0000, cfg};
      end else if (hit_presc) begin
        prdata_q <= {16'h0000, presc};
      end else if (hit_stat) begin
        prdata_q <= status;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Zero wait state, error on unmapped access
  assign rsp = {prdata_q, 1'b1, access & ~mapped};

  // prescaler at its reset value on release
  chk_presc_reset: assert property (
    @(posedge clk) disable iff (rst) $fell(rst) |-> presc == afcd_pkg::PRESC_RESET)
    else $error("prescaler not at reset value after reset");

endmodule

// ===== design/afcd_top.sv
// Audio serial port framing engine with format and prescaler registers
`timescale 1ns/1ps
module afcd_top (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire afcd_pkg::afcd_apb_req_s apb_req,
  output afcd_pkg::afcd_apb_rsp_s      apb_rsp,
  input  wire afcd_pkg::afcd_pair_s    tx_pair,
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  output afcd_pkg::afcd_pair_s         rx_pair,
  output logic                         rx_valid,
  input  wire logic                    sck_in,
  output logic                         sck_out,
  output logic                         sck_oe,
  input  wire logic                    ws_in,
  output logic                         ws_out,
  output logic                         ws_oe,
  input  wire logic                    sd_in,
  output logic                         sd_out,
  output logic                         sd_oe,
  output logic                         mclk_out,
  output logic                         mclk_oe
);
  afcd_pkg::afcd_cfg_s   cfg;
  afcd_pkg::afcd_presc_s presc;
  afcd_pkg::afcd_pair_s  tx_hold;
  afcd_pkg::afcd_pair_s  new_pair;
  afcd_pkg::afcd_pair_s  rx_work;
  afcd_pkg::afcd_pair_s  next_work;
  logic [31:0]           status;
  logic                  active;
  logic                  master;
  logic                  receive;
  logic                  run_master;
  logic                  pol;
  logic                  is_pcm;
  logic [5:0]            len_bits;
  logic [5:0]            slot_bits;
  logic [6:0]            frame_bits;
  logic [5:0]            frame_last;
  logic [4:0]            msb_pos;
  logic                  div_level;
  logic                  div_rise;
  logic                  div_fall;
  logic                  sck_norm;
  logic                  sck_prev;
  logic                  ws_last;
  logic                  slv_rise;
  logic                  slv_fall;
  logic                  launch;
  logic                  sample;
  logic                  ws_start;
  logic [5:0]            bit_idx;
  logic [5:0]            next_idx;
  logic [5:0]            cur_idx;
  logic [6:0]            tx_map;
  logic [6:0]            rx_map;
  logic                  load_now;
  logic                  tx_bit;
  logic                  frame_done;

  ////////////////////////////////////////////////////////////////////
  // Registers
  afcd_apb_regs u_regs (
    .clk    (clk),
    .rst    (rst),
    .req    (apb_req),
    .rsp    (apb_rsp),
    .cfg    (cfg),
    .presc  (presc),
    .status (status)
  );

  // Status: active, line word select, master, bit index
  assign status = {22'h000000, bit_idx, 1'b0, run_master, ws_oe ? ws_out : ws_in, active};

  ////////////////////////////////////////////////////////////////////
  // Mode decode
  // audio settings act only in audio mode
  // function switch assumed made while off
  assign active  = cfg.audio_function_select & cfg.audio_port_enable;
  // role code picks master and direction
  assign master  = (cfg.audio_role_config == afcd_pkg::ROLE_MASTER_TX) |
                   (cfg.audio_role_config == afcd_pkg::ROLE_MASTER_RX);
  assign receive = (cfg.audio_role_config == afcd_pkg::ROLE_SLAVE_RX) |
                   (cfg.audio_role_config == afcd_pkg::ROLE_MASTER_RX);
  assign run_master = active & master;
  assign pol        = cfg.idle_clock_polarity;
  assign is_pcm     = cfg.framing_standard_sel == afcd_pkg::STD_PCM;

  // sample length, forbidden code falls to 16
  always_comb begin
    case (cfg.sample_length_sel)
      afcd_pkg::LEN_24: len_bits = afcd_pkg::BITS_24;
      afcd_pkg::LEN_32: len_bits = afcd_pkg::BITS_32;
      default:          len_bits = afcd_pkg::BITS_16;
    endcase
  end

  // slot forced to 32 for every length code but 16
  assign slot_bits  = (cfg.channel_slot_width || cfg.sample_length_sel != afcd_pkg::LEN_16) ?
                      afcd_pkg::BITS_32 : afcd_pkg::BITS_16;
  assign frame_bits = {slot_bits, 1'b0};
  assign frame_last = 6'(frame_bits - 7'h01);
  assign msb_pos    = 5'(len_bits - 6'h01);

  ////////////////////////////////////////////////////////////////////
  // Bit clock sources
  // prescaler runs only as clock master
  afcd_clk_div u_div (
    .clk            (clk),
    .rst            (rst),
    .run            (run_master),
    .linear_divider (presc.linear_divider),
    .odd_adjust     (presc.odd_adjust),
    .clk_level      (div_level),
    .rise           (div_rise),
    .fall           (div_fall)
  );

  // Slave clock edges, polarity removed
  assign sck_norm = sck_in ^ pol;
  assign slv_rise = sck_norm & ~sck_prev;
  assign slv_fall = ~sck_norm & sck_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_norm;
    end
  end

  // Launch on falling, sample on rising internal edge
  assign launch = active & (master ? div_fall : slv_fall);
  assign sample = active & (master ? div_rise : slv_rise);

  // idle level follows polarity; pins gated
  assign sck_out = run_master ? (div_level ^ pol) : pol;
  assign sck_oe  = run_master;
  assign ws_oe   = run_master;
  assign sd_oe   = active & ~receive;

  // master clock pin only when enabled
  assign mclk_oe  = run_master & presc.master_clock_out_en;
  assign mclk_out = mclk_oe & div_level;

  ////////////////////////////////////////////////////////////////////
  // Position helpers
  // I2S data lags the word select by one bit
  function automatic logic [5:0] data_pos(input logic [5:0] idx);
    logic [5:0] p;
    p = idx;
    if (cfg.framing_standard_sel == afcd_pkg::STD_I2S) begin
      p = (idx == 6'h00) ? frame_last : 6'(idx - 6'h01);
    end
    return p;
  endfunction

  // Returns valid, channel and sample bit for a line bit
  function automatic logic [6:0] bit_map(input logic [5:0] idx);
    logic [5:0] p;
    logic [5:0] s;
    logic [5:0] b;
    logic       ch;
    logic       ok;
    p  = data_pos(idx);
    ch = p >= slot_bits;
    s  = ch ? 6'(p - slot_bits) : p;
    if (cfg.framing_standard_sel == afcd_pkg::STD_RIGHT) begin
      ok = s >= 6'(slot_bits - len_bits);
      b  = 6'(slot_bits - 6'h01 - s);
    end else begin
      ok = s < len_bits;
      b  = 6'(len_bits - 6'h01 - s);
    end
    return {ok, ch, b[4:0]};
  endfunction

  // word select or frame sync per standard
  function automatic logic ws_level(input logic [5:0] idx);
    logic r;
    r = 1'b0;
    case (cfg.framing_standard_sel)
      afcd_pkg::STD_I2S: r = idx >= slot_bits;
      afcd_pkg::STD_PCM: r = cfg.pcm_sync_length ? (idx < afcd_pkg::PCM_LONG_BITS) :
                                                   (idx == frame_last);
      default:           r = idx < slot_bits;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Frame sequencer
  assign next_idx = (bit_idx == frame_last) ? 6'h00 : 6'(bit_idx + 6'h01);

  // Slave frame start seen on the word select line
  assign ws_start = (cfg.framing_standard_sel == afcd_pkg::STD_I2S) ? (ws_last & ~ws_in) :
                                                                      (~ws_last & ws_in);

  always_comb begin
    cur_idx = bit_idx;
    if (!master && ws_start) begin
      cur_idx = (is_pcm && !cfg.pcm_sync_length) ? frame_last : 6'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_idx <= afcd_pkg::IDX_RESET;
    end else if (!active) begin
      bit_idx <= frame_last;
    end else if (launch) begin
      bit_idx <= next_idx;
    end else if (sample) begin
      bit_idx <= cur_idx;
    end
  end

  // Slave word select history; follows the line while off, no false sync
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ws_last <= 1'b0;
    end else if (sample || !active) begin
      ws_last <= ws_in;
    end
  end

  // Master word select driven at launch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ws_out <= 1'b0;
    end else if (!run_master) begin
      ws_out <= 1'b0;
    end else if (launch) begin
      ws_out <= ws_level(next_idx);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit path
  always_comb tx_map = bit_map(next_idx);
  assign load_now = launch & (next_idx == 6'h00) & ~receive;
  assign tx_ready = load_now;
  assign new_pair = tx_valid ? tx_pair : '0;

  // New frame bits come straight from the port at load
  always_comb begin
    if (load_now && !tx_map[5]) begin
      tx_bit = new_pair.left[tx_map[4:0]];
    end else if (tx_map[5]) begin
      tx_bit = tx_hold.right[tx_map[4:0]];
    end else begin
      tx_bit = tx_hold.left[tx_map[4:0]];
    end
  end

  // Sample pair held for the frame, zeros on underrun
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_hold <= '0;
    end else if (load_now) begin
      tx_hold <= new_pair;
    end
  end

  // MSB first, padding bits driven low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sd_out <= 1'b0;
    end else if (!active || receive) begin
      sd_out <= 1'b0;
    end else if (launch) begin
      sd_out <= tx_map[6] & tx_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive path
  always_comb rx_map = bit_map(cur_idx);
  always_comb frame_done = data_pos(cur_idx) == frame_last;

  always_comb begin
    next_work = rx_work;
    if (rx_map[6] && rx_map[5]) begin
      next_work.right[rx_map[4:0]] = sd_in;
    end else if (rx_map[6]) begin
      next_work.left[rx_map[4:0]] = sd_in;
    end
  end

  // Frame assembled, published at its last bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_work  <= '0;
      rx_pair  <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!active || !receive) begin
        rx_work <= '0;
      end else if (sample) begin
        rx_work <= frame_done ? '0 : next_work;
        if (frame_done) begin
          rx_pair  <= next_work;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_left_start;
    launch && next_idx == 6'h00 && run_master && !receive &&
      cfg.framing_standard_sel == afcd_pkg::STD_LEFT;
  endsequence

  sequence s_long_start;
    launch && next_idx == 6'h00 && run_master && is_pcm && cfg.pcm_sync_length;
  endsequence

  chk_idle_clock: assert property (
    !run_master |-> sck_out == pol)
    else $error("serial clock not at idle polarity");

  chk_pcm_short: assert property (
    run_master && is_pcm && !cfg.pcm_sync_length && ws_out |-> bit_idx == frame_last)
    else $error("short frame sync outside last bit");

  chk_pcm_long: assert property (
    s_long_start |=> ws_out && bit_idx == 6'h00)
    else $error("long frame sync not high at frame start");

  chk_i2s_select: assert property (
    launch && run_master && cfg.framing_standard_sel == afcd_pkg::STD_I2S
      |=> ws_out == (bit_idx >= slot_bits))
    else $error("word select wrong for standard framing");

  chk_msb_first: assert property (
    s_left_start |=> sd_out == tx_hold.left[msb_pos])
    else $error("left sample MSB not first on line");

  chk_slot_width: assert property (
    cfg.sample_length_sel != afcd_pkg::LEN_16 |-> frame_last == 6'h3f)
    else $error("slot not forced to 32 bits");

  chk_mclk_gate: assert property (
    !presc.master_clock_out_en |-> !mclk_oe && !mclk_out)
    else $error("master clock driven while disabled");

  chk_slave_divider: assert property (
    $rose(div_level) |-> $past(run_master))
    else $error("prescaler ran outside master role");

  chk_audio_only: assert property (
    !cfg.audio_function_select |-> !sck_oe && !ws_oe && !sd_oe && !tx_ready && !rx_valid)
    else $error("audio pins active in plain serial mode");

  chk_role_pins: assert property (
    active && cfg.audio_role_config == afcd_pkg::ROLE_SLAVE_RX |-> !sck_oe && !ws_oe && !sd_oe)
    else $error("slave receiver drives a pin");

endmodule

// ===== verif/afcd_codec.sv
// Behavioural audio codec on the serial side of the port
`timescale 1ns/1ps
module afcd_codec (
  input  wire logic gen,
  input  wire logic sck,
  output logic      sck_gen,
  output logic      ws_gen,
  output logic      sd_gen
);
  localparam logic [15:0] LEFT_WORD  = 16'hc35a;
  localparam logic [15:0] RIGHT_WORD = 16'h1e87;
  int cnt;
  initial begin
    sck_gen = 1'b0;
    ws_gen  = 1'b0;
    sd_gen  = 1'b0;
    cnt     = 0;
  end
  // Bit clock for slave roles, parked low; edges on falling clk only
  always begin
    #20;
    sck_gen = gen ? ~sck_gen : 1'b0;
  end
  // Word select every 16 bits, fixed words MSB first one bit after it
  always @(negedge sck) begin
    cnt    <= (cnt + 1) % 16;
    sd_gen <= ws_gen ? RIGHT_WORD[15 - cnt] : LEFT_WORD[15 - cnt];
    if (cnt == 15) begin
      ws_gen <= ~ws_gen;
    end
  end
endmodule

// ===== verif/i2s_format_and_clock_divider_bench.sv
// Self-checking bench for the audio format and clock divider block
`timescale 1ns/1ps
module i2s_format_and_clock_divider_bench;
  logic                    clk, rst, tx_valid, tx_ready, rx_valid, gen;
  logic                    sck_out, sck_oe, ws_out, ws_oe, sd_out, sd_oe;
  logic                    mclk_out, mclk_oe, sck_gen, ws_gen, sd_gen;
  afcd_pkg::afcd_apb_req_s apb_req;
  afcd_pkg::afcd_apb_rsp_s apb_rsp;
  afcd_pkg::afcd_pair_s    tx_pair, rx_pair;
  int                      error_cnt, n_checks;
  logic [31:0]             q;
  logic                    e;
  int                      h, l;

  afcd_top uut (.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .tx_pair(tx_pair), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_pair(rx_pair),
    .rx_valid(rx_valid), .sck_in(sck_oe ? sck_out : sck_gen), .sck_out(sck_out),
    .sck_oe(sck_oe), .ws_in(ws_oe ? ws_out : ws_gen), .ws_out(ws_out), .ws_oe(ws_oe),
    .sd_in(sd_oe ? sd_out : sd_gen), .sd_out(sd_out), .sd_oe(sd_oe),
    .mclk_out(mclk_out), .mclk_oe(mclk_oe));
  afcd_codec codec (.gen(gen), .sck(sck_oe ? sck_out : sck_gen), .sck_gen(sck_gen),
    .ws_gen(ws_gen), .sd_gen(sd_gen));

  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb_req <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wc(input logic [15:0] d);
    apb(1'b1, afcd_pkg::CFG_OFFSET, {16'h0000, d});
  endtask
  task automatic wp(input logic [15:0] d);
    apb(1'b1, afcd_pkg::PRESC_OFFSET, {16'h0000, d});
  endtask
  // Program with the port off, then enable
  task automatic run(input logic [15:0] p, input logic [15:0] c);
    wc(c & 16'h0800);
    wc(c & 16'hfbff);
    wp(p);
    wc(c);
  endtask
  task automatic stop(input logic [15:0] c);
    wc(c & 16'hfbff);
    wc(16'h0000);
  endtask
  // Cycles a line spends at a level, from its next entry to it
  task automatic span(input bit w, input logic lv, output int n);
    int t;
    t = 0;
    n = 0;
    while ((w ? sck_out : ws_out) === lv && t < 3000) begin @(negedge clk); t++; end
    while ((w ? sck_out : ws_out) !== lv && t < 3000) begin @(negedge clk); t++; end
    while ((w ? sck_out : ws_out) === lv && t < 3000) begin @(negedge clk); t++; n++; end
    if (t >= 3000) error_cnt++;
  endtask

  task automatic t_regs();
    apb(1'b0, afcd_pkg::PRESC_OFFSET, 32'h0);
    chk(q, 32'h00000002);
    chk({sck_out, mclk_oe, sck_oe}, 32'h0);
    wp(16'hffff);
    apb(1'b0, afcd_pkg::PRESC_OFFSET, 32'h0);
    chk(q, 32'h000003ff);
    wc(16'hfbff);
    apb(1'b0, afcd_pkg::CFG_OFFSET, 32'h0);
    chk(q, 32'h00000bbf);
    apb(1'b1, 8'h40, 32'hffffffff);
    chk(e, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    wc(16'h0000);
    wp(16'h0002);
  endtask
  task automatic t_div();
    logic [15:0] tab [4] = '{16'h0202, 16'h0203, 16'h0302, 16'h0105};
    foreach (tab[i]) begin
      run(tab[i], 16'h0e00);
      span(1'b1, 1'b1, h);
      span(1'b1, 1'b0, l);
      chk(h, tab[i][7:0]);
      chk(h + l, 2 * tab[i][7:0] + tab[i][8]);
      chk({mclk_out, mclk_oe, sck_oe}, {tab[i][9], tab[i][9], 1'b1});
      stop(16'h0e00);
    end
  endtask
  task automatic t_frame();
    logic [15:0] c [9] = '{16'h0e00, 16'h0e01, 16'h0e02, 16'h0e04, 16'h0e10,
      16'h0e20, 16'h0e30, 16'h0eb0, 16'h0e80};
    int x [9] = '{64, 128, 128, 128, 64, 64, 4, 52, 64};
    foreach (c[i]) begin
      run(16'h0002, c[i]);
      span(1'b0, 1'b1, h);
      chk(h, x[i]);
      stop(c[i]);
    end
  endtask
  // Left-justified master transmit: first left sample MSB first
  task automatic t_tx();
    logic [15:0] w;
    w = 16'h0000;
    run(16'h0002, 16'h0e10);
    @(negedge clk);
    h = 0;
    while (tx_ready !== 1'b1 && h < 900) begin @(negedge clk); h++; end
    chk(tx_ready, 1'b1);
    repeat (16) begin
      @(posedge sck_out);
      w = {w[14:0], sd_out};
    end
    chk(w, 16'ha5c3);
    chk(sd_oe, 1'b1);
    stop(16'h0e10);
  endtask
  task automatic t_modes();
    wc(16'h0808);
    chk(sck_out, 1'b1);
    wc(16'h0800);
    chk(sck_out, 1'b0);
    run(16'h0202, 16'h0600);
    repeat (40) @(posedge clk);
    chk({sck_oe, ws_oe, mclk_oe}, 32'h0);
    stop(16'h0600);
    run(16'h0202, 16'h0f00);
    chk({sck_oe, ws_oe, sd_oe}, 32'h6);
    stop(16'h0f00);
    gen <= 1'b1;
    run(16'h0202, 16'h0c00);
    chk({sck_oe, ws_oe, sd_oe, mclk_oe}, 32'h2);
    stop(16'h0c00);
    run(16'h0202, 16'h0d00);
    chk({sck_oe, ws_oe, sd_oe, mclk_oe}, 32'h0);
    h = 0;
    l = 0;
    while (l < 3 && h < 2000) begin
      @(negedge clk);
      h++;
      if (rx_valid === 1'b1) l++;
    end
    chk(rx_valid, 1'b1);
    chk(rx_pair.left, 32'h0000c35a);
    chk(rx_pair.right, 32'h00001e87);
    stop(16'h0d00);
    gen <= 1'b0;
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog
  initial begin
    #300000;
    error_cnt++;
    complete_run();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    apb_req = '0;
    tx_pair = {32'h0000a5c3, 32'h00003c5a};
    tx_valid = 1'b1;
    gen = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_div();
    t_frame();
    t_tx();
    t_modes();
    complete_run();
  end
endmodule
